// ### mwm_bridge.sv
/*
  memory write mirror bridge: on the active card snoops processor writes
  into a write buffer and sends them over the link; on the standby card
  takes link writes and masters them into local memory.
  assumes link and nonvolatile memory ports run on ref_clk_i; role and
  enable switch are asynchronous pins.
*/
`timescale 1ns/10ps
`default_nettype none
`include "mwm_map.svh"

module mwm_bridge #(
  parameter int N = `MWM_NUM_RANGES,
  parameter int DEPTH = `MWM_BUF_DEPTH
) (
  input wire logic ref_clk_i,
  input wire logic reset_i,
  input wire logic role_active_i,
  input wire logic enable_switch_i,
  input wire logic pb_valid_i,
  input wire logic pb_write_i,
  input wire logic pb_dma_i,
  input wire mwm_pkg::mwm_addr_t pb_addr_i,
  input wire mwm_pkg::mwm_data_t pb_data_i,
  output logic pb_stall_o,
  output logic lk_tx_valid_o,
  output mwm_pkg::mwm_addr_t lk_tx_addr_o,
  output mwm_pkg::mwm_data_t lk_tx_data_o,
  input wire logic lk_tx_ready_i,
  input wire logic lk_rx_valid_i,
  input wire mwm_pkg::mwm_addr_t lk_rx_addr_i,
  input wire mwm_pkg::mwm_data_t lk_rx_data_i,
  output logic lk_rx_ready_o,
  output logic bm_req_o,
  output mwm_pkg::mwm_addr_t bm_addr_o,
  output mwm_pkg::mwm_data_t bm_data_o,
  input wire logic bm_ack_i,
  output logic cfg_req_o,
  output logic [$clog2(2*N)-1:0] cfg_addr_o,
  input wire logic cfg_valid_i,
  input wire logic [31:0] cfg_data_i,
  output logic cfg_done_o
);
  import mwm_pkg::*;

  localparam int AW = $clog2(DEPTH);
  localparam int CW = $clog2(2*N);

  // ==========================================================
  // pin synchronisers
  logic act_meta_q, act_q, act_prev_q, sw_meta_q, sw_q, sw_prev_q;
  logic act_meta_d, act_d, act_prev_d, sw_meta_d, sw_d, sw_prev_d;
  logic flush, sw_rise;

  always_comb begin
    act_meta_d = role_active_i;
    act_d = act_meta_q;
    act_prev_d = act_q;
    sw_meta_d = enable_switch_i;
    sw_d = sw_meta_q;
    sw_prev_d = sw_q;
  end

  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      act_meta_q <= 1'b0;
      act_q <= 1'b0;
      act_prev_q <= 1'b0;
      sw_meta_q <= 1'b0;
      sw_q <= 1'b0;
      sw_prev_q <= 1'b0;
    end else begin
      act_meta_q <= act_meta_d;
      act_q <= act_d;
      act_prev_q <= act_prev_d;
      sw_meta_q <= sw_meta_d;
      sw_q <= sw_d;
      sw_prev_q <= sw_prev_d;
    end
  end

  assign flush = act_q ^ act_prev_q;
  // sw_prev_q leaves reset low, so a switch already on at power return rises too
  assign sw_rise = sw_q & ~sw_prev_q;

  // ==========================================================
  // configuration loader
  mwm_cfg_e cfg_st_q, cfg_st_d;
  logic [CW-1:0] cfg_idx_q, cfg_idx_d;
  logic [N-1:0][31:0] base_q, base_d, limit_q, limit_d;

  always_comb begin
    cfg_st_d = cfg_st_q;
    cfg_idx_d = cfg_idx_q;
    base_d = base_q;
    limit_d = limit_q;
    case (cfg_st_q)
      MWM_CFG_IDLE, MWM_CFG_DONE: begin
        if (sw_rise) begin
          cfg_st_d = MWM_CFG_LOAD;
          cfg_idx_d = '0;
        end
      end
      MWM_CFG_LOAD: begin
        if (cfg_valid_i) begin
          if (cfg_idx_q[0] == `MWM_CFG_BASE_SLOT) begin
            base_d[cfg_idx_q[CW-1:1]] = cfg_data_i;
          end else begin
            limit_d[cfg_idx_q[CW-1:1]] = cfg_data_i;
          end
          if (cfg_idx_q == CW'(2*N-1)) begin
            cfg_st_d = MWM_CFG_DONE;
          end else begin
            cfg_idx_d = cfg_idx_q + CW'(1);
          end
        end
      end
      default: cfg_st_d = MWM_CFG_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      cfg_st_q <= MWM_CFG_IDLE;
      cfg_idx_q <= '0;
      base_q <= '0;
      limit_q <= '0;
    end else begin
      cfg_st_q <= cfg_st_d;
      cfg_idx_q <= cfg_idx_d;
      base_q <= base_d;
      limit_q <= limit_d;
    end
  end

  assign cfg_req_o = (cfg_st_q == MWM_CFG_LOAD);
  assign cfg_addr_o = cfg_idx_q;
  assign cfg_done_o = (cfg_st_q == MWM_CFG_DONE);

  // ==========================================================
  // address selection
  logic main_hit, dev_hit;

  mwm_range_match #(.N(N)) i_mwm_range_match (
    .addr_i(pb_addr_i),
    .base_i(base_q),
    .limit_i(limit_q),
    .enable_i(cfg_done_o),
    .main_hit_o(main_hit),
    .dev_hit_o(dev_hit),
    .dev_sel_o()
  );

  logic snoop_sel;
  // only processor writes on the active card, after configuration
  assign snoop_sel = act_q & ~flush & cfg_done_o & pb_valid_i & pb_write_i
                     & ~pb_dma_i
                     & (main_hit | dev_hit);

  // ==========================================================
  // write buffer, shared by both roles, strictly first in first out
  mwm_entry_s mem_q [DEPTH];
  logic [AW:0] wr_q, wr_d, rd_q, rd_d, cnt;
  logic full, empty, push, pop;
  mwm_entry_s push_ent, head;

  assign cnt = wr_q - rd_q;
  assign full = (cnt == (AW+1)'(DEPTH));
  assign empty = (cnt == '0);
  assign head = mem_q[rd_q[AW-1:0]];

  assign pb_stall_o = snoop_sel & full;
  assign lk_rx_ready_o = ~act_q & ~flush & ~full;
  assign lk_tx_valid_o = act_q & ~flush & ~empty;
  assign bm_req_o = ~act_q & ~flush & ~empty;
  assign lk_tx_addr_o = head.addr;
  assign lk_tx_data_o = head.data;
  assign bm_addr_o = head.addr;
  assign bm_data_o = head.data;

  always_comb begin
    push = 1'b0;
    push_ent = '{addr: pb_addr_i, data: pb_data_i};
    if (act_q) begin
      push = snoop_sel & ~full;
    end else begin
      push = lk_rx_valid_i & lk_rx_ready_o;
      push_ent = '{addr: lk_rx_addr_i, data: lk_rx_data_i};
    end
    pop = (lk_tx_valid_o & lk_tx_ready_i) | (bm_req_o & bm_ack_i);
    wr_d = wr_q + (AW+1)'(push);
    rd_d = rd_q + (AW+1)'(pop);
    if (flush) begin
      wr_d = '0;
      rd_d = '0;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      wr_q <= '0;
      rd_q <= '0;
    end else begin
      wr_q <= wr_d;
      rd_q <= rd_d;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (push) begin
      mem_q[wr_q[AW-1:0]] <= push_ent;
    end
  end

  // ==========================================================
  // checks
  property p_active_target;
    @(posedge ref_clk_i) disable iff (reset_i)
    act_q |-> !bm_req_o;
  endproperty
  a_active_target: assert property (p_active_target) else $error("active card mastered bus");

  property p_standby_master;
    @(posedge ref_clk_i) disable iff (reset_i)
    (!act_q && lk_rx_valid_i && lk_rx_ready_o) |=> (bm_req_o || flush);
  endproperty
  a_standby_master: assert property (p_standby_master) else $error("standby write not driven");

  property p_dev_capture;
    @(posedge ref_clk_i) disable iff (reset_i)
    (act_q && !flush && cfg_done_o && pb_valid_i && pb_write_i && !pb_dma_i && dev_hit && !full)
      |=> (!empty || flush);
  endproperty
  a_dev_capture: assert property (p_dev_capture) else $error("device range write lost");

  property p_no_capture_outside;
    @(posedge ref_clk_i) disable iff (reset_i)
    (act_q && !flush && !(main_hit || dev_hit)) |=> (cnt <= $past(cnt));
  endproperty
  a_no_capture_outside: assert property (p_no_capture_outside) else $error("unselected write buffered");

  property p_tx_content;
    @(posedge ref_clk_i) disable iff (reset_i)
    (act_q && !flush && empty && snoop_sel) |=>
      (flush || (lk_tx_valid_o && lk_tx_addr_o == $past(pb_addr_i) && lk_tx_data_o == $past(pb_data_i)));
  endproperty
  a_tx_content: assert property (p_tx_content) else $error("link word differs from captured write");

  property p_main_mirror;
    @(posedge ref_clk_i) disable iff (reset_i)
    (act_q && !flush && cfg_done_o && pb_valid_i && pb_write_i && !pb_dma_i
      && pb_addr_i < `MWM_MAIN_LIMIT) |-> (pb_stall_o || push);
  endproperty
  a_main_mirror: assert property (p_main_mirror) else $error("main memory write not mirrored");

  property p_dma_skip;
    @(posedge ref_clk_i) disable iff (reset_i)
    (act_q && pb_valid_i && pb_dma_i) |-> !push;
  endproperty
  a_dma_skip: assert property (p_dma_skip) else $error("dma write mirrored");

  property p_cfg_start;
    @(posedge ref_clk_i) disable iff (reset_i)
    $rose(sw_q) |=> (cfg_req_o && !cfg_done_o && cfg_addr_o == '0);
  endproperty
  a_cfg_start: assert property (p_cfg_start) else $error("switch on did not start load");

  property p_order;
    @(posedge ref_clk_i) disable iff (reset_i)
    (!act_q && !flush && cnt == (AW+1)'(1) && pop && lk_rx_valid_i && lk_rx_ready_o)
      |=> (flush || bm_addr_o == $past(lk_rx_addr_i));
  endproperty
  a_order: assert property (p_order) else $error("standby write out of order");
endmodule
`default_nettype wire

// ### mwm_map.svh
/*
  constants of the memory write mirror: address ranges, buffer sizing,
  configuration image layout.
  assumes 32-bit physical addresses on the processor bus.
*/
`ifndef MWM_MAP_SVH
`define MWM_MAP_SVH

// ==========================================================
// main memory range (128 megabyte dynamic memory)
`define MWM_MAIN_BASE 32'h0000_0000
`define MWM_MAIN_LIMIT 32'h0800_0000

// ==========================================================
// device ranges and write buffer
`define MWM_NUM_RANGES 4
`define MWM_BUF_DEPTH 16

// ==========================================================
// configuration image: range k base at word 2k, limit at word 2k+1
`define MWM_CFG_WORDS_PER_RANGE 2
`define MWM_CFG_BASE_SLOT 1'b0
`define MWM_CFG_LIMIT_SLOT 1'b1

`endif

// ### mwm_pkg.sv
/*
  types of the memory write mirror.
  assumes mwm_map.svh is on the include path.
*/
`default_nettype none
package mwm_pkg;
  typedef logic [31:0] mwm_addr_t;
  typedef logic [31:0] mwm_data_t;
  typedef struct packed {
    mwm_addr_t addr;
    mwm_data_t data;
  } mwm_entry_s;
  typedef enum logic [1:0] {
    MWM_CFG_IDLE,
    MWM_CFG_LOAD,
    MWM_CFG_DONE
  } mwm_cfg_e;
endpackage
`default_nettype wire

// ### mwm_range_match.sv
/*
  address comparison: tells whether an address lies in main memory or in
  one of the configured device ranges.
  assumes ranges are half open, base inclusive and limit exclusive.
*/
`timescale 1ns/10ps
`default_nettype none
`include "mwm_map.svh"

module mwm_range_match #(
  parameter int N = `MWM_NUM_RANGES
) (
  input wire mwm_pkg::mwm_addr_t addr_i,
  input wire logic [N-1:0][31:0] base_i,
  input wire logic [N-1:0][31:0] limit_i,
  input wire logic enable_i,
  output logic main_hit_o,
  output logic dev_hit_o,
  output logic [N-1:0] dev_sel_o
);
  import mwm_pkg::*;

  function automatic logic in_range(mwm_addr_t a, mwm_addr_t lo, mwm_addr_t hi);
    return (a >= lo) && (a < hi);
  endfunction

  // ==========================================================
  // comparators
  assign main_hit_o = in_range(addr_i, `MWM_MAIN_BASE, `MWM_MAIN_LIMIT);

  for (genvar k = 0; k < N; k++) begin : g_rng
    assign dev_sel_o[k] = enable_i & in_range(addr_i, base_i[k], limit_i[k]);
  end

  assign dev_hit_o = |dev_sel_o;
endmodule
`default_nettype wire

// ### mwm_peer_model.sv
/*
  peer bridge model: link receiver on the standby card, logs each entry.
  assumes hold_i and slow_i are driven at the falling clock edge.
*/
`timescale 1ns/10ps
`default_nettype none
module mwm_peer_model (
  input wire logic clk_i,
  input wire logic hold_i,
  input wire logic slow_i,
  input wire logic valid_i,
  input wire mwm_pkg::mwm_addr_t addr_i,
  input wire mwm_pkg::mwm_data_t data_i,
  output logic ready_o
);
  import mwm_pkg::*;
  mwm_entry_s q[$];
  initial ready_o = 1'b0;
  // ==========================================================
  // accept prompt, every other cycle, or stall fully
  always @(negedge clk_i) ready_o <= !hold_i && (!slow_i || !ready_o);
  always @(posedge clk_i) if (valid_i && ready_o) q.push_back({addr_i, data_i});
endmodule
`default_nettype wire

// ### test_mwm_bridge.sv
/*
  testbench of the mirror bridge: config load, active snooping, standby replay.
  assumes mwm_peer_model on the link side and a memory model acking writes.
*/
`timescale 1ns/10ps
`default_nettype none
`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin errors++; \
  $display("[ERR] %s exp %h got %h", n, e, g); end end
module test_mwm_bridge;
  import mwm_pkg::*;
  logic clk = 0, rst = 1, role = 1, sw = 0, pv = 0, pw = 0, pd = 0, stall;
  logic tv, tr, rv = 0, rr, bq, ack = 0, cq, cv = 0, done, hold = 0, slow = 0;
  mwm_addr_t pa = 0, ta, ra = 0, ba;
  mwm_data_t pdat = 0, tdat, rdat = 0, bd;
  logic [2:0] ca;
  logic [31:0] cd = 0;
  logic [31:0] img [8];
  mwm_entry_s eq[$], mq[$];
  int errors = 0, cmp_count = 0;
  mwm_bridge i_mwm_bridge (.ref_clk_i(clk), .reset_i(rst), .role_active_i(role),
    .enable_switch_i(sw), .pb_valid_i(pv), .pb_write_i(pw), .pb_dma_i(pd),
    .pb_addr_i(pa), .pb_data_i(pdat), .pb_stall_o(stall), .lk_tx_valid_o(tv),
    .lk_tx_addr_o(ta), .lk_tx_data_o(tdat), .lk_tx_ready_i(tr), .lk_rx_valid_i(rv),
    .lk_rx_addr_i(ra), .lk_rx_data_i(rdat), .lk_rx_ready_o(rr), .bm_req_o(bq),
    .bm_addr_o(ba), .bm_data_o(bd), .bm_ack_i(ack), .cfg_req_o(cq), .cfg_addr_o(ca),
    .cfg_valid_i(cv), .cfg_data_i(cd), .cfg_done_o(done));
  mwm_peer_model i_mwm_peer_model (.clk_i(clk), .hold_i(hold), .slow_i(slow),
    .valid_i(tv), .addr_i(ta), .data_i(tdat), .ready_o(tr));
  always #20 clk = ~clk;
  // ==========================================================
  // nonvolatile memory and local memory models
  always @(negedge clk) begin
    cv <= cq && !cv;
    cd <= img[ca];
    ack <= bq && !ack;
  end
  always @(posedge clk) if (bq && ack) mq.push_back({ba, bd});
  // ==========================================================
  // tasks
  task finish_test;
    $display("errors=%0d compares=%0d", errors, cmp_count);
    if (errors == 0 && cmp_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task wr(input mwm_addr_t a, input logic dma, input logic w, input logic sel);
    @(negedge clk);
    pv = 1; pw = w; pd = dma; pa = a; pdat = ~a;
    if (sel) eq.push_back({a, ~a});
    #1;
    while (stall) @(negedge clk);
  endtask
  task idle;
    @(negedge clk);
    pv = 0;
  endtask
  task chk_tx;
    repeat (60) @(negedge clk);
    `CHK("tx count", eq.size(), i_mwm_peer_model.q.size())
    foreach (eq[i]) `CHK("tx entry", eq[i], i_mwm_peer_model.q[i])
    eq = {};
    i_mwm_peer_model.q = {};
  endtask
  task wait_done;
    int k;
    for (k = 0; k < 200 && done !== 1'b1; k++) @(negedge clk);
    `CHK("cfg done", 1'b1, done)
  endtask
  task rx(input mwm_addr_t a);
    @(negedge clk);
    rv = 1; ra = a; rdat = ~a;
    eq.push_back({a, ~a});
    #1;
    while (!rr) @(negedge clk);
  endtask
  // ==========================================================
  // scenarios
  task sc_unconfigured;
    repeat (4) @(negedge clk);
    `CHK("done early", 1'b0, done)
    wr(32'h100, 0, 1, 0);
    idle;
    chk_tx;
  endtask
  task sc_config;
    sw = 1;
    wait_done;
    `CHK("cfg req idle", 1'b0, cq)
  endtask
  task sc_select;
    slow = 1;
    wr(32'h0000_0100, 0, 1, 1);
    wr(32'h07ff_fffc, 0, 1, 1);
    wr(32'h0800_0000, 0, 1, 0);
    wr(32'h0000_0200, 1, 1, 0);
    wr(32'h0000_0300, 0, 0, 0);
    wr(32'h1000_0000, 0, 1, 1);
    wr(32'h1000_0100, 0, 1, 0);
    wr(32'h3000_000c, 0, 1, 1);
    wr(32'h2000_0000, 0, 1, 0);
    idle;
    chk_tx;
    `CHK("rx ready active", 1'b0, rr)
  endtask
  task sc_full;
    hold = 1;
    slow = 0;
    fork
      begin
        for (int i = 0; i < 17; i++) wr(32'h400 + 4 * i, 0, 1, 1);
        idle;
      end
      begin
        repeat (40) @(negedge clk);
        `CHK("stall", 1'b1, stall)
        hold = 0;
      end
    join
    chk_tx;
    `CHK("no master", 0, mq.size())
  endtask
  task sc_reset_reload;
    rst = 1;
    repeat (5) @(negedge clk);
    rst = 0;
    repeat (2) @(negedge clk);
    `CHK("done reset", 1'b0, done)
    wait_done;
  endtask
  task sc_standby;
    role = 0;
    repeat (5) @(negedge clk);
    `CHK("rx ready standby", 1'b1, rr)
    wr(32'h0000_0500, 0, 1, 0);
    idle;
    chk_tx;
    for (int i = 0; i < 3; i++) rx(32'h0000_0600 - 8 * i);
    @(negedge clk) rv = 0;
    repeat (30) @(negedge clk);
    `CHK("bm count", eq.size(), mq.size())
    foreach (eq[i]) `CHK("bm entry", eq[i], mq[i])
  endtask
  // ==========================================================
  // main sequence and watchdog
  initial begin
    repeat (20000) @(posedge clk);
    errors++;
    finish_test;
  end
  initial begin
    img = '{32'h1000_0000, 32'h1000_0100, 32'hffff_0000, 32'hffff_0000,
      32'hffff_0000, 32'hffff_0000, 32'h3000_0000, 32'h3000_0010};
    repeat (5) @(posedge clk);
    @(negedge clk) rst = 0;
    sc_unconfigured;
    sc_config;
    sc_select;
    sc_full;
    sc_reset_reload;
    sc_standby;
    finish_test;
  end
endmodule
`default_nettype wire
